// ### logic/ces_sequencer.v
// Purpose: Co-add exposure sequencer with APB command registers.
// Assumes: Ring and waveform emitter answer with one-cycle pulses.
// Notes: Functional notes below.
// Functional notes
// RQ1: Loop once per co-add, count passes, exit at total or run-ok clear.
// RQ2: Send begin message each co-add, wait for its return.
// RQ3: Ring nodes forward every message; last node returns it here.
// RQ4: On begin return, capture timestamp, then run the array clear.
// RQ5: After clear, emit readout waveform sample-count times (only in MCS; CDS emits one readout, single mode none and goes to integration).
// RQ6: Integration idles waiting for time expiry or host message.
// RQ7: On expiry emit readouts sample-count times, then count the co-add (sample count used in MCS only; single and CDS emit one readout).
// RQ8: Nodes accumulate second-set sum minus first-set sum per co-add.
// RQ9: Normal exit sends finish message, waits for return, then idles.
// RQ10: Frame data forwarded to host only once back in idle.
// RQ11: Abort in integration: emit readouts, clear run-ok, echo abort.
// RQ12: Exit with run-ok clear forwards abort to ring, no frame data (data_fwd_en still rises once back in idle).
// RQ13: Exposure command in milliseconds stored as microsecond ticks.
// RQ14: Sampling mode stored and forwarded to the ring.
// RQ15: Pixel rate in kHz, limited to 500, triggers waveform recompose.
// RQ16: Co-add count command replaces the loop terminal count.
// RQ17: Sample count command replaces readouts per set.
// RQ18: Quadrant offsets saturate to 0..4095 and go over serial DAC.
// RQ19: Bias code goes to the bias DAC, spectrometer variant only.
// RQ20: Counts and exposure time latched at frame start.
// RQ21: Bias code saturated to 0..4095 like the offsets.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "ces_defines.vh"

module ces_sequencer #(
   parameter HAS_BIAS = 1
) (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Acquisition ring
   output reg ring_tx_valid,
   output reg [2:0] ring_tx_msg,
   output reg [1:0] ring_tx_mode,
   input wire ring_rx_valid,
   input wire [2:0] ring_rx_msg,
   // Waveform emitter
   output reg wave_go,
   output reg wave_read,
   input wire wave_done,
   output reg recompose,
   output reg [9:0] pixel_rate_khz,
   // Host side
   output reg abort_echo,
   output reg data_fwd_en,
   output reg frame_busy,
   // Serial DAC pins
   output wire ofs_sclk,
   output wire ofs_sdata,
   output wire ofs_load_n,
   output wire bias_sclk,
   output wire bias_sdata,
   output wire bias_load_n
);

   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_LOOP = 4'h1;
   localparam [3:0] S_BEGIN = 4'h2;
   localparam [3:0] S_WBEGIN = 4'h3;
   localparam [3:0] S_WCLEAR = 4'h4;
   localparam [3:0] S_SET = 4'h5;
   localparam [3:0] S_INTEG = 4'h6;
   localparam [3:0] S_END = 4'h7;
   localparam [3:0] S_WEND = 4'h8;
   localparam [3:0] S_ABORT = 4'h9;
   function [11:0] sat12;
      input [31:0] v;
      sat12 = v[31] ? 12'h000 : (v > `CES_CODE_MAX) ? {`CES_CODE_W{1'b1}} : v[11:0];
   endfunction
   function is_quad;
      input [11:0] a;
      is_quad = (a >= `CES_A_QUAD0) && (a <= `CES_A_QUAD3) && (a[1:0] == 2'h0);
   endfunction

   // ***************************************************************
   // Microsecond tick timer
   // ***************************************************************
   reg [5:0] us_div;
   reg [31:0] us_count;
   wire us_tick = ({26'h0, us_div} == `CES_US_CYC - 1);
   always @(posedge sys_clk) begin
      if (!nrst) begin
         us_div <= 6'h00;
         us_count <= 32'h0000_0000;
      end else if (us_tick) begin
         us_div <= 6'h00;
         us_count <= us_count + 32'h0000_0001;
      end else begin
         us_div <= us_div + 6'h01;
      end
   end

   // ***************************************************************
   // APB access
   // ***************************************************************
   wire ofs_busy;
   wire bias_busy;
   wire acc = psel & penable;
   wire hit_bias = (paddr == `CES_A_BIAS);
   wire stall = pwrite & ((is_quad(paddr) & ofs_busy) | (hit_bias & bias_busy));
   wire mapped = (paddr <= `CES_A_CNUM) && (paddr[1:0] == 2'h0);
   wire wr = acc & pready & pwrite & ~pslverr;
   wire go_cmd = wr & (paddr == `CES_A_CTRL) & pwdata[`CES_CTRL_GO];
   wire abort_cmd = wr & (paddr == `CES_A_CTRL) & pwdata[`CES_CTRL_ABORT];
   wire [11:0] quad_off = paddr - `CES_A_QUAD0;
   wire [1:0] quad_idx = quad_off[3:2];
   wire [31:0] rate_max = `CES_RATE_MAX_KHZ;
   reg [31:0] itime_us;
   reg [1:0] mode;
   reg [15:0] coadds;
   reg [15:0] samples;
   reg [11:0] quad_code [0:3];
   reg [11:0] bias_code;
   reg mode_pend;
   reg [31:0] stamp;
   reg [15:0] coadd_num;
   reg run_ok;
   reg [3:0] state;
   reg [31:0] rd_mux;
   always @* begin
      case (paddr)
         `CES_A_ITIME: rd_mux = itime_us;
         `CES_A_MODE: rd_mux = {30'h0, mode};
         `CES_A_RATE: rd_mux = {22'h0, pixel_rate_khz};
         `CES_A_COADDS: rd_mux = {16'h0, coadds};
         `CES_A_SAMPLES: rd_mux = {16'h0, samples};
         `CES_A_BIAS: rd_mux = {20'h0, bias_code};
         `CES_A_STATUS: rd_mux = {24'h0, run_ok, frame_busy, ofs_busy, bias_busy, state};
         `CES_A_STAMP: rd_mux = stamp;
         `CES_A_CNUM: rd_mux = {16'h0, coadd_num};
         default: rd_mux = is_quad(paddr) ? {20'h0, quad_code[quad_idx]} : 32'h0000_0000;
      endcase
   end
   always @(posedge sys_clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc & ~pready & ~stall;
         pslverr <= acc & ~pready & ~stall & ~mapped;
         prdata <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ***************************************************************
   // Parameter commands
   // ***************************************************************
   always @(posedge sys_clk) begin
      if (!nrst) begin
         itime_us <= `CES_RST_ITIME_US;
         mode <= `CES_RST_MODE;
         coadds <= `CES_RST_COADDS;
         samples <= `CES_RST_SAMPLES;
         pixel_rate_khz <= `CES_RST_RATE;
         recompose <= 1'b0;
         bias_code <= 12'h000;
      end else begin
         recompose <= 1'b0;
         if (wr) begin
            case (paddr)
               `CES_A_ITIME: itime_us <= pwdata * `CES_MS_US; // [RQ13]
               `CES_A_MODE: mode <= pwdata[1:0]; // [RQ14]
               `CES_A_COADDS: coadds <= pwdata[15:0]; // [RQ16]
               `CES_A_SAMPLES: samples <= pwdata[15:0]; // [RQ17]
               `CES_A_RATE: begin
                  pixel_rate_khz <= (pwdata > rate_max) ? rate_max[9:0] : pwdata[9:0]; // [RQ15]
                  recompose <= 1'b1; // [RQ15]
               end
               `CES_A_BIAS: if (HAS_BIAS != 0)
                  bias_code <= sat12(pwdata); // [RQ19] [RQ21]
               default: ;
            endcase
         end
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_quad
         always @(posedge sys_clk) begin
            if (!nrst)
               quad_code[gi] <= 12'h000;
            else if (wr && is_quad(paddr) && quad_idx == gi)
               quad_code[gi] <= sat12(pwdata); // [RQ18]
         end
      end
   endgenerate

   // ***************************************************************
   // Serial DAC links
   // ***************************************************************
   ces_dac_link u_ofs_dac (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(wr & is_quad(paddr)), // [RQ18]
      .word({2'h0, quad_idx, sat12(pwdata)}),
      .busy(ofs_busy),
      .sclk(ofs_sclk),
      .sdata(ofs_sdata),
      .load_n(ofs_load_n)
   );
   ces_dac_link u_bias_dac (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(wr & hit_bias & (HAS_BIAS != 0)), // [RQ19]
      .word({4'h0, sat12(pwdata)}),
      .busy(bias_busy),
      .sclk(bias_sclk),
      .sdata(bias_sdata),
      .load_n(bias_load_n)
   );

   // ***************************************************************
   // Exposure sequencer
   // ***************************************************************
   reg [15:0] lat_coadds;
   reg [15:0] lat_samples;
   reg [31:0] lat_itime;
   reg [1:0] lat_mode;
   reg [15:0] rd_cnt;
   reg [31:0] integ_left;
   reg second_set;
   reg wave_wait;
   reg aborting;
   wire [15:0] set_len = (lat_mode == `CES_MODE_MCS) ? lat_samples : 16'h0001;
   always @(posedge sys_clk) begin
      if (!nrst) begin
         state <= S_IDLE;
         lat_coadds <= 16'h0000;
         lat_samples <= 16'h0000;
         lat_itime <= 32'h0000_0000;
         lat_mode <= 2'h0;
         rd_cnt <= 16'h0000;
         integ_left <= 32'h0000_0000;
         second_set <= 1'b0;
         wave_wait <= 1'b0;
         aborting <= 1'b0;
         coadd_num <= 16'h0000;
         run_ok <= 1'b0;
         stamp <= 32'h0000_0000;
         mode_pend <= 1'b0;
         ring_tx_valid <= 1'b0;
         ring_tx_msg <= 3'h0;
         ring_tx_mode <= 2'h0;
         wave_go <= 1'b0;
         wave_read <= 1'b0;
         abort_echo <= 1'b0;
         data_fwd_en <= 1'b0;
         frame_busy <= 1'b0;
      end else begin
         ring_tx_valid <= 1'b0;
         wave_go <= 1'b0;
         abort_echo <= 1'b0;
         data_fwd_en <= (state == S_IDLE); // [RQ10]
         frame_busy <= (state != S_IDLE);
         if (wr && paddr == `CES_A_MODE)
            mode_pend <= 1'b1;
         case (state)
            S_IDLE: begin
               if (mode_pend && !(wr && paddr == `CES_A_MODE)) begin
                  mode_pend <= 1'b0;
                  ring_tx_valid <= 1'b1;
                  ring_tx_msg <= `CES_MSG_MODE; // [RQ14]
                  ring_tx_mode <= mode;
               end else if (go_cmd) begin
                  lat_coadds <= coadds; // [RQ20]
                  lat_samples <= samples;
                  lat_itime <= itime_us;
                  lat_mode <= mode;
                  coadd_num <= 16'h0000;
                  run_ok <= 1'b1;
                  aborting <= 1'b0;
                  state <= S_LOOP;
               end
            end
            S_LOOP: // [RQ1] [RQ9] [RQ12]
               state <= !run_ok ? S_ABORT : (coadd_num == lat_coadds) ? S_END : S_BEGIN;
            S_BEGIN: begin
               ring_tx_valid <= 1'b1;
               ring_tx_msg <= `CES_MSG_BEGIN; // [RQ2]
               state <= S_WBEGIN;
            end
            S_WBEGIN: begin
               if (ring_rx_valid && ring_rx_msg == `CES_MSG_BEGIN) begin // [RQ2] [RQ3]
                  stamp <= us_count; // [RQ4]
                  wave_go <= 1'b1;
                  wave_read <= 1'b0; // [RQ4]
                  state <= S_WCLEAR;
               end
            end
            S_WCLEAR: begin
               if (wave_done) begin
                  rd_cnt <= 16'h0000;
                  wave_wait <= 1'b0;
                  if (lat_mode == `CES_MODE_SINGLE) begin
                     integ_left <= lat_itime;
                     state <= S_INTEG;
                  end else begin
                     second_set <= 1'b0;
                     state <= S_SET; // [RQ5]
                  end
               end
            end
            S_SET: begin
               if (wave_wait) begin
                  if (wave_done) begin
                     wave_wait <= 1'b0;
                     rd_cnt <= rd_cnt + 16'h0001;
                  end
               end else if (rd_cnt == set_len) begin
                  rd_cnt <= 16'h0000;
                  if (!second_set) begin
                     integ_left <= lat_itime;
                     state <= S_INTEG;
                  end else begin
                     if (aborting) begin
                        run_ok <= 1'b0; // [RQ11]
                        abort_echo <= 1'b1; // [RQ11]
                     end else begin
                        coadd_num <= coadd_num + 16'h0001; // [RQ1] [RQ7]
                     end
                     state <= S_LOOP;
                  end
               end else begin
                  wave_go <= 1'b1; // [RQ5] [RQ7]
                  wave_read <= 1'b1;
                  wave_wait <= 1'b1;
               end
            end
            S_INTEG: begin
               if (abort_cmd || integ_left == 32'h0000_0000) begin // [RQ6] [RQ7]
                  aborting <= abort_cmd; // [RQ11]
                  second_set <= 1'b1;
                  state <= S_SET;
               end else if (us_tick) begin
                  integ_left <= integ_left - 32'h0000_0001;
               end
            end
            S_END, S_ABORT: begin
               ring_tx_valid <= 1'b1;
               ring_tx_msg <= (state == S_END) ? `CES_MSG_END : `CES_MSG_ABORT; // [RQ9] [RQ12]
               state <= (state == S_END) ? S_WEND : S_IDLE;
            end
            S_WEND: if (ring_rx_valid && ring_rx_msg == `CES_MSG_END)
               state <= S_IDLE; // [RQ9]
            default: state <= S_IDLE;
         endcase
      end
   end

endmodule // ces_sequencer

// ### logic/ces_defines.vh
// Purpose: Shared constants of the co-add exposure sequencer.
// Assumes: 40 MHz system clock, 32-bit APB data, byte addresses.
// Notes: Definitions only.
`ifndef CES_DEFINES_VH
`define CES_DEFINES_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define CES_A_CTRL 12'h000
`define CES_A_ITIME 12'h004
`define CES_A_MODE 12'h008
`define CES_A_RATE 12'h00c
`define CES_A_COADDS 12'h010
`define CES_A_SAMPLES 12'h014
`define CES_A_QUAD0 12'h018
`define CES_A_QUAD3 12'h024
`define CES_A_BIAS 12'h028
`define CES_A_STATUS 12'h02c
`define CES_A_STAMP 12'h030
`define CES_A_CNUM 12'h034

// ***************************************************************
// Control bits and encodings
// ***************************************************************
`define CES_CTRL_GO 0
`define CES_CTRL_ABORT 1
`define CES_MODE_SINGLE 2'h0
`define CES_MODE_CDS 2'h1
`define CES_MODE_MCS 2'h2
`define CES_MSG_BEGIN 3'h1
`define CES_MSG_END 3'h2
`define CES_MSG_ABORT 3'h3
`define CES_MSG_MODE 3'h4

// ***************************************************************
// Reset values and limits
// ***************************************************************
`define CES_RST_ITIME_US 32'h0000_03e8
`define CES_RST_MODE 2'h2
`define CES_RST_RATE 10'h064
`define CES_RST_COADDS 16'h0001
`define CES_RST_SAMPLES 16'h0001
`define CES_RATE_MAX_KHZ 500
`define CES_CODE_MAX 4095
`define CES_CODE_W 12
`define CES_DAC_BITS 16

// ***************************************************************
// Timing
// ***************************************************************
`define CES_CLK_NS 25
`define CES_US_NS 1000
`define CES_MS_US 1000
`define CES_US_CYC ((`CES_US_NS + `CES_CLK_NS - 1) / `CES_CLK_NS)
`define CES_SCLK_HALF_NS 100
`define CES_SCLK_HALF_CYC ((`CES_SCLK_HALF_NS + `CES_CLK_NS - 1) / `CES_CLK_NS)

`endif

// ### logic/ces_dac_link.v
// Purpose: Serial DAC writer, one 16-bit frame per start pulse.
// Assumes: Start is only given while busy is low.
// Notes: Data changes on the falling serial clock, load_n low frames a word.
`timescale 1ns/100ps
`include "ces_defines.vh"

module ces_dac_link (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // Request
   input wire start,
   input wire [15:0] word,
   output reg busy,
   // Serial pins
   output reg sclk,
   output reg sdata,
   output reg load_n
);

   reg [15:0] shreg;
   reg [3:0] bitn;
   reg [2:0] div;

   always @(posedge sys_clk) begin
      if (!nrst) begin
         busy <= 1'b0;
         sclk <= 1'b0;
         sdata <= 1'b0;
         load_n <= 1'b1;
         shreg <= 16'h0000;
         bitn <= 4'h0;
         div <= 3'h0;
      end else if (!busy) begin
         if (start) begin
            busy <= 1'b1;
            shreg <= word;
            sdata <= word[15];
            bitn <= 4'h0;
            div <= 3'h0;
            load_n <= 1'b0;
            sclk <= 1'b0;
         end
      end else if ({29'h0, div} == `CES_SCLK_HALF_CYC - 1) begin
         div <= 3'h0;
         if (!sclk) begin
            sclk <= 1'b1;
         end else begin
            sclk <= 1'b0;
            if ({28'h0, bitn} == `CES_DAC_BITS - 1) begin
               busy <= 1'b0;
               load_n <= 1'b1;
            end else begin
               bitn <= bitn + 4'h1;
               shreg <= {shreg[14:0], 1'b0};
               sdata <= shreg[14];
            end
         end
      end else begin
         div <= div + 3'h1;
      end
   end

endmodule // ces_dac_link

// ### sim/ces_sequencer_checker.sv
// Purpose: Concurrent checks on the ports of the co-add exposure sequencer.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached to every sequencer instance by the bind at the foot.
`timescale 1ns/100ps

module ces_sequencer_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Ring, emitter, host side and offset DAC load
   input wire logic ring_rx_valid,
   input wire logic [2:0] ring_rx_msg,
   input wire logic ring_tx_valid,
   input wire logic [2:0] ring_tx_msg,
   input wire logic wave_go,
   input wire logic wave_read,
   input wire logic recompose,
   input wire logic [9:0] pixel_rate_khz,
   input wire logic abort_echo,
   input wire logic data_fwd_en,
   input wire logic frame_busy,
   input wire logic ofs_load_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   wire apb_done = psel && penable && pready;

   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_bad_addr: assert property (apb_done && paddr > 12'h034 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_clear_first: assert property (
      ring_rx_valid && ring_rx_msg == 3'h1 && frame_busy |-> ##[1:2] (wave_go && !wave_read))
      else $error("no array clear after begin returned");
   a_wave_in_frame: assert property (wave_go |-> frame_busy)
      else $error("waveform started while idle");
   a_rate_limit: assert property (pixel_rate_khz <= 10'h1f4)
      else $error("pixel rate above limit");
   a_rate_recompose: assert property (
      apb_done && pwrite && paddr == 12'h00c |-> ##[1:2] recompose)
      else $error("no recompose after rate write");
   a_fwd_idle: assert property (frame_busy [*3] |-> !data_fwd_en)
      else $error("data forwarding enabled during a frame");
   a_abort_ring: assert property (
      abort_echo |-> ##[0:6] (ring_tx_valid && ring_tx_msg == 3'h3))
      else $error("abort not passed into the ring");
   a_dac_frame: assert property ($fell(ofs_load_n) |-> ##[100:200] $rose(ofs_load_n))
      else $error("offset DAC frame length wrong");
endmodule // ces_sequencer_checker

bind ces_sequencer ces_sequencer_checker chk_u (.sys_clk, .nrst, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .ring_rx_valid, .ring_rx_msg, .ring_tx_valid,
   .ring_tx_msg, .wave_go, .wave_read, .recompose, .pixel_rate_khz, .abort_echo,
   .data_fwd_en, .frame_busy, .ofs_load_n);

// ### sim/ces_ring_model.sv
// Purpose: Acquisition ring and waveform emitter stand-in.
// Assumes: Latencies given by the bench are at least one cycle.
// Notes: The return message lines carry a changing pattern when not valid.
`timescale 1ns/100ps

module ces_ring_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Latencies
   input wire logic [7:0] ring_lat,
   input wire logic [7:0] wave_lat,
   // Ring
   input wire logic ring_tx_valid,
   input wire logic [2:0] ring_tx_msg,
   output logic ring_rx_valid,
   output logic [2:0] ring_rx_msg,
   // Emitter
   input wire logic wave_go,
   output logic wave_done
);
   logic [2:0] msg_q[$];
   int due_q[$];
   int cyc = 0;
   int wdue = -1;

   initial begin
      ring_rx_valid = 1'b0;
      ring_rx_msg = 3'h0;
      wave_done = 1'b0;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      ring_rx_valid <= 1'b0;
      ring_rx_msg <= ring_rx_msg + 3'h3;
      wave_done <= 1'b0;
      if (!nrst) begin
         msg_q.delete();
         due_q.delete();
         wdue <= -1;
      end else begin
         // Every message goes round the ring and comes back unchanged.
         if (ring_tx_valid) begin
            msg_q.push_back(ring_tx_msg);
            due_q.push_back(cyc + int'(ring_lat));
         end
         if (due_q.size() > 0 && due_q[0] <= cyc) begin
            ring_rx_valid <= 1'b1;
            ring_rx_msg <= msg_q.pop_front();
            void'(due_q.pop_front());
         end
         if (wave_go) begin
            wdue <= cyc + int'(wave_lat);
         end
         if (wdue == cyc) begin
            wave_done <= 1'b1;
         end
      end
   end
endmodule // ces_ring_model

// ### sim/test_coadd_exposure_sequencer.sv
// Purpose: Self-checking bench for the co-add exposure sequencer.
// Assumes: Integration times are kept short so the run stays brief.
// Notes: The driver queues expected results and a monitor compares them.
`timescale 1ns/100ps
`include "ces_defines.vh"

module test_coadd_exposure_sequencer;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] ring_lat = 8'h01;
   logic [7:0] wave_lat = 8'h02;
   logic [31:0] prdata;
   logic pready, pslverr, ring_tx_valid, ring_rx_valid, wave_go, wave_read, wave_done;
   logic recompose, abort_echo, data_fwd_en, frame_busy, bias_sclk, bias_sdata, bias_load_n;
   logic [15:0] bias_sh, exp_dac[$];
   logic [2:0] ring_tx_msg, ring_rx_msg;
   logic [1:0] ring_tx_mode;
   logic [9:0] pixel_rate_khz;
   logic [32:0] exp_rd[$];
   logic [4:0] exp_msg[$];
   int failures = 0;
   int n_checks = 0;
   int n_reads = 0;
   int n_clears = 0;
   int n_echo = 0;

   always #12.5 sys_clk = ~sys_clk;

   ces_sequencer #(.HAS_BIAS(1)) dut_u (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ring_tx_valid, .ring_tx_msg, .ring_tx_mode,
      .ring_rx_valid, .ring_rx_msg, .wave_go, .wave_read, .wave_done, .recompose,
      .pixel_rate_khz, .abort_echo, .data_fwd_en, .frame_busy, .ofs_sclk(), .ofs_sdata(),
      .ofs_load_n(), .bias_sclk, .bias_sdata, .bias_load_n);
   ces_ring_model ring_u (.sys_clk, .nrst, .ring_lat, .wave_lat, .ring_tx_valid,
      .ring_tx_msg, .ring_rx_valid, .ring_rx_msg, .wave_go, .wave_done);

   // *****
   // Compare, report and bus tasks
   // *****
   task check_word(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task check_msg(input logic [4:0] got, input logic [4:0] exp);
      check_word({28'h0, got}, {28'h0, exp});
   endtask
   task check_dac(input logic [15:0] got, input logic [15:0] exp);
      check_word({17'h0, got}, {17'h0, exp});
   endtask

   task end_of_test;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (pready !== 1'b1 && i < 400);
      if (i >= 400) begin
         failures++;
         end_of_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task rd(input logic [11:0] a, input logic err, input logic [31:0] exp);
      exp_rd.push_back({err, exp});
      apb(1'b0, a, 32'h0);
   endtask

   task wait_idle;
      int i;
      i = 0;
      while ((exp_msg.size() > 0 || frame_busy !== 1'b0) && i < 60000) begin
         @(posedge sys_clk);
         i++;
      end
      if (i >= 60000) begin
         failures++;
         end_of_test();
      end
      @(posedge sys_clk);
   endtask

   // *****
   // Monitor
   // *****
   always @(posedge sys_clk) begin
      if (nrst) begin
         if (psel && penable && pready && !pwrite)
            check_word({pslverr, prdata}, exp_rd.size() > 0 ? exp_rd.pop_front() : 'x);
         if (ring_tx_valid)
            check_msg({ring_tx_msg == 3'h4 ? ring_tx_mode : 2'h0, ring_tx_msg},
               exp_msg.size() > 0 ? exp_msg.pop_front() : 5'bx);
         if (wave_go && wave_read)
            n_reads++;
         if (wave_go && !wave_read)
            n_clears++;
         if (abort_echo)
            n_echo++;
      end
   end
   always @(posedge bias_sclk)
      bias_sh <= {bias_sh[14:0], bias_sdata};
   always @(posedge bias_load_n)
      if (nrst)
         check_dac(bias_sh, exp_dac.size() > 0 ? exp_dac.pop_front() : 16'hxxxx);

   // *****
   // Main sequence
   // *****
   initial begin
      int s, m, r, c, per;
      void'($urandom(79521));
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      rd(`CES_A_ITIME, 1'b0, `CES_RST_ITIME_US);
      rd(`CES_A_MODE, 1'b0, 32'd2);
      rd(`CES_A_RATE, 1'b0, 32'd100);
      rd(`CES_A_COADDS, 1'b0, 32'd1);
      rd(`CES_A_SAMPLES, 1'b0, 32'd1);
      rd(12'h040, 1'b1, 32'h0);
      $display("test reset_values done");
      apb(1'b1, `CES_A_ITIME, 32'd3);
      rd(`CES_A_ITIME, 1'b0, 32'd3000);
      r = $urandom_range(499, 1);
      apb(1'b1, `CES_A_RATE, r);
      rd(`CES_A_RATE, 1'b0, r);
      apb(1'b1, `CES_A_RATE, 32'd700);
      rd(`CES_A_RATE, 1'b0, 32'd500);
      apb(1'b1, `CES_A_COADDS, 32'd5);
      rd(`CES_A_COADDS, 1'b0, 32'd5);
      apb(1'b1, `CES_A_SAMPLES, 32'd7);
      rd(`CES_A_SAMPLES, 1'b0, 32'd7);
      for (c = 0; c < 4; c++) begin
         apb(1'b1, `CES_A_QUAD0 + 12'(c * 4), 32'd5000);
         rd(`CES_A_QUAD0 + 12'(c * 4), 1'b0, 32'd4095);
         apb(1'b1, `CES_A_QUAD0 + 12'(c * 4), 32'hffff_fff0);
         rd(`CES_A_QUAD0 + 12'(c * 4), 1'b0, 32'h0);
      end
      r = $urandom_range(4095, 0);
      apb(1'b1, `CES_A_QUAD3, r);
      rd(`CES_A_QUAD3, 1'b0, r);
      exp_dac.push_back(16'h0fff);
      apb(1'b1, `CES_A_BIAS, 32'd9999);
      rd(`CES_A_BIAS, 1'b0, 32'd4095);
      exp_dac.push_back(16'h007b);
      apb(1'b1, `CES_A_BIAS, 32'd123);
      rd(`CES_A_BIAS, 1'b0, 32'd123);
      $display("test commands done");
      for (m = 0; m < 3; m++) begin
         s = $urandom_range(4, 1);
         per = (m == 0) ? 1 : (m == 1) ? 2 : 2 * s;
         ring_lat <= 8'(1 + m * 9);
         wave_lat <= 8'(1 + m * 5);
         n_reads = 0;
         n_clears = 0;
         exp_msg.push_back({2'(m), 3'h4});
         apb(1'b1, `CES_A_MODE, m);
         apb(1'b1, `CES_A_ITIME, 32'd0);
         apb(1'b1, `CES_A_COADDS, 32'd2);
         apb(1'b1, `CES_A_SAMPLES, s);
         exp_msg.push_back(5'h01);
         exp_msg.push_back(5'h01);
         exp_msg.push_back(5'h02);
         apb(1'b1, `CES_A_CTRL, 32'd1);
         apb(1'b1, `CES_A_SAMPLES, 32'd9);
         wait_idle();
         check_word(33'(n_reads), 33'(2 * per));
         check_word(33'(n_clears), 33'd2);
         rd(`CES_A_CNUM, 1'b0, 32'd2);
         check_word({32'h0, data_fwd_en}, 33'h1);
         $display("test frame mode %0d done", m);
      end
      s = 2;
      n_reads = 0;
      n_clears = 0;
      n_echo = 0;
      apb(1'b1, `CES_A_SAMPLES, s);
      apb(1'b1, `CES_A_COADDS, 32'd3);
      apb(1'b1, `CES_A_ITIME, 32'd1);
      exp_msg.push_back(5'h01);
      exp_msg.push_back(5'h03);
      apb(1'b1, `CES_A_CTRL, 32'd1);
      c = 0;
      while (n_reads < s && c < 2000) begin
         @(posedge sys_clk);
         c++;
      end
      check_word(33'(c < 2000), 33'h1);
      repeat (20) @(posedge sys_clk);
      apb(1'b1, `CES_A_CTRL, 32'd1);
      apb(1'b1, `CES_A_CTRL, 32'd2);
      wait_idle();
      check_word(33'(n_reads), 33'(2 * s));
      check_word(33'(n_echo), 33'd1);
      check_word(33'(n_clears), 33'd1);
      rd(`CES_A_CNUM, 1'b0, 32'd0);
      check_word(33'(exp_dac.size()), 33'h0);
      $display("test abort done");
      end_of_test();
   end
endmodule // test_coadd_exposure_sequencer
